/* verilog/converter_clock_pkg.sv */
package converter_clock_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_PB_OS_HIGH = 8'h0d;
    localparam logic [7:0] ADDR_PB_OS_LOW = 8'h0e;
    localparam logic [7:0] ADDR_RSVD_A_FIRST = 8'h0f;
    localparam logic [7:0] ADDR_RSVD_A_LAST = 8'h11;
    localparam logic [7:0] ADDR_REC_COARSE = 8'h12;
    localparam logic [7:0] ADDR_REC_MOD = 8'h13;
    localparam logic [7:0] ADDR_REC_OS = 8'h14;
    localparam logic [7:0] ADDR_RSVD_B_FIRST = 8'h15;
    localparam logic [7:0] ADDR_RSVD_B_LAST = 8'h18;
    localparam logic [7:0] ADDR_CLKOUT_SEL = 8'h19;

    // Field positions and widths
    localparam int POWER_BIT = 7;
    localparam int PB_HIGH_W = 2;
    localparam int SEL_W = 3;

    // Values after reset
    localparam logic [1:0] PB_HIGH_RST = 2'h0;
    localparam logic [7:0] PB_LOW_RST = 8'h80;
    localparam logic [10:0] PB_RATIO_RST = 11'h080;
    localparam logic [7:0] REC_COARSE_RST = 8'h01;
    localparam logic [7:0] REC_MOD_RST = 8'h01;
    localparam logic [7:0] REC_OS_RST = 8'h80;
    localparam logic [8:0] DIV_RATIO_RST = 9'h001;

    // Divide ratios that an all-zero field stands for
    localparam logic [8:0] DIV7_ZERO_RATIO = 9'h080;
    localparam logic [8:0] DIV8_ZERO_RATIO = 9'h100;
    localparam logic [10:0] PB_OS_ZERO_RATIO = 11'h400;

    // Sources of the clock-output divider input
    typedef enum logic [2:0] {
        SRC_MASTER_PIN = 3'b000,
        SRC_BIT_CLK_PIN = 3'b001,
        SRC_DATA_IN_PIN = 3'b010,
        SRC_PLL = 3'b011,
        SRC_PB_PROC = 3'b100,
        SRC_PB_MOD = 3'b101,
        SRC_REC_PROC = 3'b110,
        SRC_REC_MOD = 3'b111
    } clkout_src_e;

    // 7-bit divider field, zero means 128
    function automatic logic [8:0] div7_ratio(input logic [6:0] f);
        return (f == 7'h00) ? DIV7_ZERO_RATIO : {2'b00, f};
    endfunction

    // 8-bit divider field, zero means 256
    function automatic logic [8:0] div8_ratio(input logic [7:0] f);
        return (f == 8'h00) ? DIV8_ZERO_RATIO : {1'b0, f};
    endfunction

    // 10-bit playback ratio, zero means 1024
    function automatic logic [10:0] pb_os_ratio(input logic [9:0] v);
        return (v == 10'h000) ? PB_OS_ZERO_RATIO : {1'b0, v};
    endfunction

    // Reserved read-only locations
    function automatic logic is_reserved(input logic [7:0] a);
        return ((a >= ADDR_RSVD_A_FIRST) && (a <= ADDR_RSVD_A_LAST)) ||
               ((a >= ADDR_RSVD_B_FIRST) && (a <= ADDR_RSVD_B_LAST));
    endfunction

endpackage

/* verilog/ratio_divider.sv */
module ratio_divider (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic run_i,
    input wire logic src_en_i,
    input wire logic [8:0] ratio_i,
    output logic tick_o
);
    import converter_clock_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic [8:0] ratio;
        logic tick;
    } div_state_s;

    div_state_s st_ff;
    div_state_s nxt_st;

    // Count source pulses; new ratio taken at period end or while stopped
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run_i) begin
            nxt_st.cnt = 9'h000;
            nxt_st.ratio = ratio_i;
        end else if (src_en_i) begin
            if (st_ff.cnt >= st_ff.ratio - 9'h001) begin
                nxt_st.cnt = 9'h000;
                nxt_st.tick = 1'b1;
                nxt_st.ratio = ratio_i;
            end else begin
                nxt_st.cnt = st_ff.cnt + 9'h001;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= '{cnt: 9'h000, ratio: DIV_RATIO_RST, tick: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;

    a_tick_has_cause: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        tick_o |-> $past(src_en_i) && $past(run_i))
        else $error("divider tick without a source pulse");

    a_ratio_one_every: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        run_i && src_en_i && st_ff.ratio == 9'h001 |=> tick_o)
        else $error("divide by one missed a pulse");

    a_ratio_midperiod: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        run_i && $past(run_i) && !$past(tick_o) && st_ff.cnt != 9'h000 |-> $stable(st_ff.ratio))
        else $error("divide ratio changed inside a period");

endmodule

/* verilog/converter_clock_dividers.sv */
module converter_clock_dividers (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic codec_clk_en_i,
    input wire logic playback_proc_clk_i,
    input wire logic playback_modulator_clock_i,
    input wire logic master_clk_pin_i,
    input wire logic bit_clk_pin_i,
    input wire logic data_in_pin_i,
    input wire logic pll_clk_i,
    output logic [7:0] rdata_o,
    output logic [10:0] playback_oversample_ratio_o,
    output logic record_proc_clk_o,
    output logic record_modulator_clock_o,
    output logic record_sample_en_o,
    output logic clock_output_div_input_o
);
    import converter_clock_pkg::*;

    typedef struct packed {
        logic [1:0] pb_high;
        logic [7:0] pb_low;
        logic high_armed;
        logic [10:0] pb_ratio;
        logic [7:0] rec_coarse;
        logic [7:0] rec_mod;
        logic [7:0] rec_os;
        logic [2:0] sel_req;
        logic [2:0] sel_act;
        logic [7:0] rdata;
        logic rec_proc;
        logic rec_modclk;
        logic rec_sample;
        logic clk_out;
    } ctl_state_s;

    ctl_state_s st_ff;
    ctl_state_s nxt_st;
    logic coarse_tick;
    logic mod_tick;
    logic os_tick;
    logic rec_proc_src;
    logic rec_mod_src;
    logic [7:0] src_vec;
    logic sel_src;

    // Record clock sources, with bypass while a divider is off
    always_comb begin
        rec_proc_src = st_ff.rec_coarse[POWER_BIT] ? coarse_tick : playback_proc_clk_i;
        rec_mod_src = st_ff.rec_mod[POWER_BIT] ? mod_tick : playback_modulator_clock_i;
        src_vec = {rec_mod_src, rec_proc_src, playback_modulator_clock_i, playback_proc_clk_i,
                   pll_clk_i, data_in_pin_i, bit_clk_pin_i, master_clk_pin_i};
        sel_src = src_vec[st_ff.sel_act];
    end

    // Coarse record divider on the codec clock
    ratio_divider u_coarse_div (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(st_ff.rec_coarse[POWER_BIT]),
        .src_en_i(codec_clk_en_i),
        .ratio_i(div7_ratio(st_ff.rec_coarse[6:0])),
        .tick_o(coarse_tick)
    );

    // Modulator record divider on the record processing clock
    ratio_divider u_mod_div (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(st_ff.rec_mod[POWER_BIT]),
        .src_en_i(rec_proc_src),
        .ratio_i(div7_ratio(st_ff.rec_mod[6:0])),
        .tick_o(mod_tick)
    );

    // Record oversampling divider on the record modulator clock
    ratio_divider u_os_div (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(1'b1),
        .src_en_i(rec_mod_src),
        .ratio_i(div8_ratio(st_ff.rec_os)),
        .tick_o(os_tick)
    );

    // Register writes, reads and clock outputs
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rec_proc = rec_proc_src;
        nxt_st.rec_modclk = rec_mod_src;
        nxt_st.rec_sample = os_tick;
        nxt_st.clk_out = sel_src;
        // Source switch only while output is low
        if (!st_ff.clk_out) begin
            nxt_st.sel_act = st_ff.sel_req;
        end
        if (wr_en_i) begin
            nxt_st.high_armed = (addr_i == ADDR_PB_OS_HIGH);
            unique case (addr_i)
                ADDR_PB_OS_HIGH: begin
                    nxt_st.pb_high = wdata_i[PB_HIGH_W-1:0];
                end
                ADDR_PB_OS_LOW: begin
                    nxt_st.pb_low = wdata_i;
                    if (st_ff.high_armed) begin
                        nxt_st.pb_ratio = pb_os_ratio({st_ff.pb_high, wdata_i});
                    end
                end
                ADDR_REC_COARSE: begin
                    nxt_st.rec_coarse = wdata_i;
                end
                ADDR_REC_MOD: begin
                    nxt_st.rec_mod = wdata_i;
                end
                ADDR_REC_OS: begin
                    nxt_st.rec_os = wdata_i;
                end
                ADDR_CLKOUT_SEL: begin
                    nxt_st.sel_req = wdata_i[SEL_W-1:0];
                end
                default: begin
                    // Reserved and unmapped locations ignore writes
                    nxt_st.pb_high = st_ff.pb_high;
                end
            endcase
        end
        if (rd_en_i) begin
            unique case (addr_i)
                ADDR_PB_OS_HIGH: nxt_st.rdata = {6'h00, st_ff.pb_high};
                ADDR_PB_OS_LOW: nxt_st.rdata = st_ff.pb_low;
                ADDR_REC_COARSE: nxt_st.rdata = st_ff.rec_coarse;
                ADDR_REC_MOD: nxt_st.rdata = st_ff.rec_mod;
                ADDR_REC_OS: nxt_st.rdata = st_ff.rec_os;
                ADDR_CLKOUT_SEL: nxt_st.rdata = {5'h00, st_ff.sel_req};
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= '{pb_high: PB_HIGH_RST, pb_low: PB_LOW_RST, high_armed: 1'b0,
                       pb_ratio: PB_RATIO_RST, rec_coarse: REC_COARSE_RST,
                       rec_mod: REC_MOD_RST, rec_os: REC_OS_RST, sel_req: SRC_MASTER_PIN,
                       sel_act: SRC_MASTER_PIN, rdata: 8'h00, rec_proc: 1'b0,
                       rec_modclk: 1'b0, rec_sample: 1'b0, clk_out: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign rdata_o = st_ff.rdata;
    assign playback_oversample_ratio_o = st_ff.pb_ratio;
    assign record_proc_clk_o = st_ff.rec_proc;
    assign record_modulator_clock_o = st_ff.rec_modclk;
    assign record_sample_en_o = st_ff.rec_sample;
    assign clock_output_div_input_o = st_ff.clk_out;

    a_pb_ratio_commit: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wr_en_i && addr_i == ADDR_PB_OS_LOW && st_ff.high_armed
        |=> playback_oversample_ratio_o == pb_os_ratio({$past(st_ff.pb_high), $past(wdata_i)}))
        else $error("playback ratio not applied after paired write");

    a_pb_ratio_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wr_en_i && addr_i == ADDR_PB_OS_LOW && st_ff.high_armed && st_ff.pb_high == 2'h0
        && wdata_i == 8'h00 |=> playback_oversample_ratio_o == 11'h400)
        else $error("zero playback ratio is not 1024");

    a_pb_ratio_unpaired: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wr_en_i && addr_i == ADDR_PB_OS_LOW && !st_ff.high_armed
        |=> $stable(playback_oversample_ratio_o))
        else $error("playback ratio changed on unpaired low write");

    a_rsvd_read_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        rd_en_i && is_reserved(addr_i) |=> rdata_o == 8'h00)
        else $error("reserved location read nonzero");

    a_rsvd_write_ignored: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wr_en_i && is_reserved(addr_i)
        |=> $stable(st_ff.rec_coarse) && $stable(st_ff.rec_os) && $stable(st_ff.sel_req))
        else $error("reserved write changed a register");

    a_proc_bypass: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !st_ff.rec_coarse[POWER_BIT] |=> record_proc_clk_o == $past(playback_proc_clk_i))
        else $error("record processing clock not bypassed");

    a_mod_bypass: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !st_ff.rec_mod[POWER_BIT] |=> record_modulator_clock_o
        == $past(playback_modulator_clock_i))
        else $error("record modulator clock not bypassed");

    a_clkout_route: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st_ff.sel_act == SRC_BIT_CLK_PIN |=> clock_output_div_input_o == $past(bit_clk_pin_i))
        else $error("clock output source misrouted");

    a_clkout_clean: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $changed(st_ff.sel_act) |-> !$past(clock_output_div_input_o))
        else $error("source switched while output high");

    a_os_zero_256: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st_ff.rec_os == 8'h00 |-> div8_ratio(st_ff.rec_os) == 9'h100)
        else $error("zero record ratio is not 256");

endmodule

/* verif/converter_clock_dividers_test.sv */
module converter_clock_dividers_test;
    timeunit 1ns;
    timeprecision 1ps;
    import converter_clock_pkg::*;

    // Stimulus and observed ports
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic codec_clk_en_i = 1'b1;
    logic playback_proc_clk_i = 1'b0;
    logic playback_modulator_clock_i = 1'b0;
    logic master_clk_pin_i = 1'b0;
    logic bit_clk_pin_i = 1'b0;
    logic data_in_pin_i = 1'b0;
    logic pll_clk_i = 1'b0;
    logic [7:0] rdata_o;
    logic [10:0] playback_oversample_ratio_o;
    logic record_proc_clk_o;
    logic record_modulator_clock_o;
    logic record_sample_en_o;
    logic clock_output_div_input_o;
    logic [2:0] outs;
    int failures = 0;
    int checks_done = 0;
    int seed = 32'hb2bf_e344;
    // Divider cases: register and field
    logic [7:0] da [10] = '{8'h12, 8'h12, 8'h12, 8'h12, 8'h13, 8'h13, 8'h13, 8'h14, 8'h14, 8'h14};
    logic [7:0] df [10] = '{8'h02, 8'h03, 8'h7f, 8'h00, 8'h01, 8'h05, 8'h00, 8'h04, 8'hff, 8'h00};
    logic [7:0] ra [6] = '{8'h0d, 8'h0e, 8'h12, 8'h13, 8'h14, 8'h19};
    logic [7:0] rv [6] = '{8'h00, 8'h80, 8'h01, 8'h01, 8'h80, 8'h00};

    assign outs = {record_sample_en_o, record_modulator_clock_o, record_proc_clk_o};

    converter_clock_dividers converter_clock_dividers_inst (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .codec_clk_en_i(codec_clk_en_i),
        .playback_proc_clk_i(playback_proc_clk_i),
        .playback_modulator_clock_i(playback_modulator_clock_i),
        .master_clk_pin_i(master_clk_pin_i),
        .bit_clk_pin_i(bit_clk_pin_i),
        .data_in_pin_i(data_in_pin_i),
        .pll_clk_i(pll_clk_i),
        .rdata_o(rdata_o),
        .playback_oversample_ratio_o(playback_oversample_ratio_o),
        .record_proc_clk_o(record_proc_clk_o),
        .record_modulator_clock_o(record_modulator_clock_o),
        .record_sample_en_o(record_sample_en_o),
        .clock_output_div_input_o(clock_output_div_input_o)
    );

    // 100 MHz clock
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Comparisons, one per kind of result
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected register data at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_ratio(input logic [10:0] got, input logic [10:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected playback ratio at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected clock level at %0t: got %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_period(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            failures++;
            $display("unexpected divider period at %0t: got %0d want %0d", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Register port cycles, one strobe each
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_en_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_en_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Cycles between pulses, third gap so old ratios have run out
    task automatic period(input int idx, output int p);
        repeat (3) begin
            p = 0;
            do begin
                @(posedge core_clk_i);
                #1 p++;
            end while (outs[idx] !== 1'b1 && p < 600);
        end
    endtask

    // Expected ratios
    function automatic logic [10:0] exp_ratio(input logic [1:0] hi, input logic [7:0] lo);
        return ({hi, lo} == 10'h000) ? 11'h400 : {1'b0, hi, lo};
    endfunction
    function automatic int exp_div(input logic [7:0] a, input logic [7:0] f);
        if (a == 8'h14) return (f == 8'h00) ? 256 : int'(f);
        return (f[6:0] == 7'h00) ? 128 : int'(f[6:0]);
    endfunction

    // Watchdog
    initial begin
        #500000;
        failures++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [7:0] d;
        logic [1:0] hi;
        logic [7:0] lo;
        logic [5:0] v;
        logic [5:0] m;
        int c;
        int p;
        repeat (5) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1 chk_ratio(playback_oversample_ratio_o, 11'h080);
        for (c = 0; c < 6; c++) begin
            rd(ra[c], d);
            chk_reg(d, rv[c]);
        end
        // Reserved and unmapped places keep reading zero
        for (c = 15; c <= 32; c++) begin
            if ((c >= 18 && c <= 20) || c == 25) continue;
            wr(8'(c), 8'hff);
            rd(8'(c), d);
            chk_reg(d, 8'h00);
        end
        // Paired playback ratio writes, even low bytes only
        for (c = 0; c < 10; c++) begin
            hi = (c == 0) ? 2'h0 : (c == 1) ? 2'h3 : 2'($random(seed));
            lo = (c == 0) ? 8'h00 : (c == 1) ? 8'hfe : {7'($random(seed)), 1'b0};
            wr(ADDR_PB_OS_HIGH, {6'h00, hi});
            wr(ADDR_PB_OS_LOW, lo);
            @(posedge core_clk_i);
            #1 chk_ratio(playback_oversample_ratio_o, exp_ratio(hi, lo));
            rd(ADDR_PB_OS_HIGH, d);
            chk_reg(d, {6'h00, hi});
        end
        // Lone or interrupted low writes leave the ratio alone
        wr(ADDR_PB_OS_LOW, 8'h40);
        rd(ADDR_PB_OS_LOW, d);
        chk_reg(d, 8'h40);
        chk_ratio(playback_oversample_ratio_o, exp_ratio(hi, lo));
        wr(ADDR_PB_OS_HIGH, 8'h01);
        wr(ADDR_REC_OS, 8'h80);
        wr(ADDR_PB_OS_LOW, 8'h20);
        @(posedge core_clk_i);
        #1 chk_ratio(playback_oversample_ratio_o, exp_ratio(hi, lo));
        // Divider periods with the codec enable high every cycle
        for (c = 0; c < 10; c++) begin
            wr(ADDR_REC_COARSE, 8'h81);
            wr(ADDR_REC_MOD, 8'h81);
            wr(ADDR_REC_OS, 8'h01);
            wr(da[c], (da[c] == 8'h14) ? df[c] : (8'h80 | df[c]));
            period(int'(da[c] - 8'h12), p);
            chk_period(p, exp_div(da[c], df[c]));
        end
        // Bypassed record dividers and every clock-output source
        wr(ADDR_REC_COARSE, 8'h01);
        wr(ADDR_REC_MOD, 8'h01);
        for (c = 0; c < 8; c++) begin
            // Playback clocks idle while the data-in pin feeds the clock output
            m = (c == 2) ? 6'h0f : 6'h3f;
            @(posedge core_clk_i);
            {playback_modulator_clock_i, playback_proc_clk_i, pll_clk_i, data_in_pin_i,
                bit_clk_pin_i, master_clk_pin_i} <= 6'h00;
            wr(ADDR_CLKOUT_SEL, {5'h00, c[2:0]});
            rd(ADDR_CLKOUT_SEL, d);
            chk_reg(d, {5'h00, c[2:0]});
            repeat (24) begin
                v = {playback_modulator_clock_i, playback_proc_clk_i, pll_clk_i, data_in_pin_i,
                    bit_clk_pin_i, master_clk_pin_i};
                @(posedge core_clk_i);
                {playback_modulator_clock_i, playback_proc_clk_i, pll_clk_i, data_in_pin_i,
                    bit_clk_pin_i, master_clk_pin_i} <= 6'($random(seed)) & m;
                #1 chk_bit(record_proc_clk_o, v[4]);
                chk_bit(record_modulator_clock_o, v[5]);
                // Record clocks are bypassed, so codes 6 and 7 carry the playback pins
                if (c < 6) chk_bit(clock_output_div_input_o, v[c]);
                else chk_bit(clock_output_div_input_o, v[c - 2]);
            end
        end
        // Second reset in mid-run
        // Sources quiet and reset long enough that past values are reset values
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        {playback_modulator_clock_i, playback_proc_clk_i, pll_clk_i, data_in_pin_i,
            bit_clk_pin_i, master_clk_pin_i} <= 6'h00;
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1 chk_ratio(playback_oversample_ratio_o, 11'h080);
        rd(ADDR_REC_COARSE, d);
        chk_reg(d, 8'h01);
        report_and_stop();
    end
endmodule
